// ===== inc/fabric_port_pkg.sv
// constants, field layouts and carrier types of the fabric-side port of the coding layer
// assumes one system clock shared with the user fabric logic
package fabric_port_pkg;

    // -----------------------------------------------------------------
    // coding modes
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_8B10B  = 2'b00,
        MODE_10B    = 2'b01,
        MODE_10GE   = 2'b10,
        MODE_BYPASS = 2'b11
    } coding_mode_e;

    // -----------------------------------------------------------------
    // channel bus layout
    // -----------------------------------------------------------------
    localparam int CH_BUS_W     = 80;
    localparam int TX_DATA_LSB  = 0;
    localparam int TX_DATA_W    = 64;
    localparam int TX_CTRL_LSB  = 64;
    localparam int TX_CTRL_W    = 8;
    localparam int TXQ_WR_BIT   = 79;
    localparam int LANES        = 4;
    localparam int LANE_W       = 10;
    localparam int RX_LANE_LSB  = 0;
    localparam int RX_DERR_LSB  = 40;
    localparam int RX_CERR_LSB  = 44;
    localparam int RX_INS_LSB   = 48;
    localparam int RX_DEL_LSB   = 52;
    localparam int RX_WIDE_W    = 64;
    localparam int RX_BYP_W     = 40;

    // queue flag positions
    localparam int QF_AEMPTY    = 0;
    localparam int QF_AFULL     = 1;
    localparam int QF_UNDER     = 2;
    localparam int QF_OVER      = 3;
    localparam int QF_W         = 4;

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam logic [7:0]  REG_MODE     = 8'h00;
    localparam logic [7:0]  REG_IRQ_STAT = 8'h04;
    localparam logic [7:0]  REG_IRQ_MASK = 8'h08;
    localparam logic [7:0]  REG_TXQ_STAT = 8'h0C;
    localparam logic [1:0]  MODE_RESET   = 2'h0;
    localparam int          IRQ_W        = 6;
    localparam logic [5:0]  IRQ_RESET    = 6'h00;
    localparam int          IRQ_TX_UNDER = 0;
    localparam int          IRQ_TX_OVER  = 1;
    localparam int          IRQ_RX_DERR  = 2;
    localparam int          IRQ_RX_CERR  = 3;
    localparam int          IRQ_RX_INS   = 4;
    localparam int          IRQ_RX_DEL   = 5;
    localparam int          TXQ_CNT_LSB  = 8;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [9:0] sym10;
        logic       rundisp;
        logic       is_ctrl;
        logic [7:0] data;
        logic       disp_err;
        logic       code_err;
        logic       ins;
        logic       del;
    } rx_lane_s;

    typedef rx_lane_s [LANES-1:0] rx_lanes_t;

    typedef struct packed {
        logic                 valid;
        logic [RX_WIDE_W-1:0] wide;
        logic [RX_BYP_W-1:0]  bypass;
    } rx_word_s;

    typedef struct packed {
        logic [TX_CTRL_W-1:0] ctrl;
        logic [TX_DATA_W-1:0] data;
    } tx_entry_s;

endpackage

// ===== logic/tx_queue_mem.sv
// storage array of the transmit queue
// assumes the caller never reads and writes past its own pointers
`timescale 1ns/100ps
module tx_queue_mem #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             sys_clk_i,
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic             rd_en_i,
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    // no reset on the array so it can map to block ram
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i) begin
            rd_data_o <= mem_reg[rd_addr_i];
        end
    end

endmodule

// ===== logic/pcs_fabric_port.sv
// fabric-side parallel port: transmit queue with flags, receive word packing,
// and a small register file with interrupt status and mask
// assumes fabric logic runs on sys_clk_i; all inputs are synchronous to it
`timescale 1ns/100ps
module pcs_fabric_port
    import fabric_port_pkg::*;
#(
    parameter int TXQ_DEPTH   = 16,
    parameter int TXQ_AW      = 4,
    parameter int TXQ_AE_LVL  = 2,
    parameter int TXQ_AF_LVL  = 14
) (
    input  wire logic                sys_clk_i,
    input  wire logic                sys_rst_i,
    // fabric transmit side
    input  wire logic [CH_BUS_W-1:0] tx_channel_in_bus_i,
    output logic      [QF_W-1:0]     tx_queue_flag_port_o,
    // encoder side of the transmit queue
    input  wire logic                tx_drain_i,
    output logic                     tx_out_valid_o,
    output logic      [TX_DATA_W-1:0] tx_out_data_o,
    output logic      [TX_CTRL_W-1:0] tx_out_ctrl_o,
    // decoder side of the receive path
    input  wire rx_lanes_t           rx_lanes_i,
    input  wire rx_word_s            rx_word_i,
    // fabric receive side
    output logic      [CH_BUS_W-1:0] rx_channel_out_bus_o,
    output logic                     rx_out_valid_o,
    // register port
    input  wire logic [ADDR_W-1:0]   reg_addr_i,
    input  wire logic [DATA_W-1:0]   reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [DATA_W-1:0]   reg_rdata_o,
    output logic                     irq_o
);

    localparam int CNT_W = TXQ_AW + 1;
    localparam logic [CNT_W-1:0] AE_LVL = CNT_W'(TXQ_AE_LVL);
    localparam logic [CNT_W-1:0] AF_LVL = CNT_W'(TXQ_AF_LVL);
    localparam logic [CNT_W-1:0] FULL_LVL = CNT_W'(TXQ_DEPTH);
    localparam logic [TXQ_AW-1:0] LAST_PTR = TXQ_AW'(TXQ_DEPTH - 1);

    // -----------------------------------------------------------------
    // control registers
    // -----------------------------------------------------------------
    coding_mode_e         mode_reg;
    coding_mode_e         mode_next;
    logic [IRQ_W-1:0]     irq_stat_reg;
    logic [IRQ_W-1:0]     irq_stat_next;
    logic [IRQ_W-1:0]     irq_mask_reg;
    logic [IRQ_W-1:0]     irq_mask_next;
    logic                 irq_next;
    logic [DATA_W-1:0]    rdata_next;
    logic [IRQ_W-1:0]     irq_events;

    // -----------------------------------------------------------------
    // transmit queue state
    // -----------------------------------------------------------------
    logic [TXQ_AW-1:0]    wptr_reg;
    logic [TXQ_AW-1:0]    wptr_next;
    logic [TXQ_AW-1:0]    rptr_reg;
    logic [TXQ_AW-1:0]    rptr_next;
    logic [CNT_W-1:0]     count_reg;
    logic [CNT_W-1:0]     count_next;
    logic [QF_W-1:0]      qflag_next;
    logic                 out_valid_next;
    logic                 wr_fire;
    logic                 push;
    logic                 pop;
    logic                 q_full;
    logic                 q_empty;
    tx_entry_s            wr_entry;
    tx_entry_s            rd_entry;

    // -----------------------------------------------------------------
    // receive state
    // -----------------------------------------------------------------
    logic [CH_BUS_W-1:0]  rx_bus_next;
    logic                 rx_valid_next;
    logic                 lane_mode;

    // -----------------------------------------------------------------
    // transmit queue
    // -----------------------------------------------------------------
    assign q_full  = (count_reg == FULL_LVL);
    assign q_empty = (count_reg == '0);
    // the strobe only means a queue write when the wide 10GE path is active
    assign wr_fire = (mode_reg == MODE_10GE) && tx_channel_in_bus_i[TXQ_WR_BIT];
    // a write into a full queue is dropped and flagged rather than overwriting;
    // the fabric is expected to back off on almost full
    assign push    = wr_fire && !q_full;
    assign pop     = tx_drain_i && !q_empty;

    assign wr_entry.data = tx_channel_in_bus_i[TX_DATA_LSB +: TX_DATA_W];
    assign wr_entry.ctrl = tx_channel_in_bus_i[TX_CTRL_LSB +: TX_CTRL_W];

    tx_queue_mem #(
        .WIDTH ($bits(tx_entry_s)),
        .DEPTH (TXQ_DEPTH),
        .AW    (TXQ_AW)
    ) u_tx_queue_mem (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (push),
        .wr_addr_i (wptr_reg),
        .wr_data_i (wr_entry),
        .rd_en_i   (pop),
        .rd_addr_i (rptr_reg),
        .rd_data_o (rd_entry)
    );

    assign tx_out_data_o = rd_entry.data;
    assign tx_out_ctrl_o = rd_entry.ctrl;

    always_comb begin
        wptr_next      = wptr_reg;
        rptr_next      = rptr_reg;
        count_next     = count_reg;
        out_valid_next = pop;
        if (push) begin
            wptr_next = (wptr_reg == LAST_PTR) ? '0 : wptr_reg + 1'b1;
        end
        if (pop) begin
            rptr_next = (rptr_reg == LAST_PTR) ? '0 : rptr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
        // flags are live in every mode, the queue simply takes no writes
        // outside 10GE but drains in every mode
        qflag_next             = '0;
        qflag_next[QF_AEMPTY]  = (count_next <= AE_LVL);
        qflag_next[QF_AFULL]   = (count_next >= AF_LVL);
        qflag_next[QF_UNDER]   = tx_drain_i && q_empty;
        qflag_next[QF_OVER]    = wr_fire && q_full;
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wptr_reg             <= '0;
            rptr_reg             <= '0;
            count_reg            <= '0;
            tx_out_valid_o       <= 1'b0;
            tx_queue_flag_port_o <= QF_W'(1 << QF_AEMPTY);
        end else begin
            wptr_reg             <= wptr_next;
            rptr_reg             <= rptr_next;
            count_reg            <= count_next;
            tx_out_valid_o       <= out_valid_next;
            tx_queue_flag_port_o <= qflag_next;
        end
    end

    // -----------------------------------------------------------------
    // receive word packing
    // -----------------------------------------------------------------
    assign lane_mode = (mode_reg == MODE_8B10B) || (mode_reg == MODE_10B);

    always_comb begin
        rx_bus_next   = '0;
        rx_valid_next = rx_word_i.valid;
        unique case (mode_reg)
            MODE_8B10B: begin
                for (int i = 0; i < LANES; i++) begin
                    rx_bus_next[RX_LANE_LSB + i*LANE_W +: LANE_W] =
                        {rx_lanes_i[i].rundisp, rx_lanes_i[i].is_ctrl,
                         rx_lanes_i[i].data};
                end
            end
            MODE_10B: begin
                for (int i = 0; i < LANES; i++) begin
                    // raw symbol: bit 9 and bit 8 are data, not disparity/control
                    rx_bus_next[RX_LANE_LSB + i*LANE_W +: LANE_W] =
                        rx_lanes_i[i].sym10;
                end
            end
            MODE_10GE: begin
                rx_bus_next[RX_WIDE_W-1:0] = rx_word_i.wide;
            end
            MODE_BYPASS: begin
                rx_bus_next[RX_BYP_W-1:0] = rx_word_i.bypass;
            end
        endcase
        // flags are taken in the same cycle as the lane bytes, so they
        // register together with them and never slip by a cycle
        if (lane_mode) begin
            for (int i = 0; i < LANES; i++) begin
                rx_bus_next[RX_DERR_LSB + i] = rx_lanes_i[i].disp_err;
                rx_bus_next[RX_CERR_LSB + i] = rx_lanes_i[i].code_err;
                rx_bus_next[RX_INS_LSB + i]  = rx_lanes_i[i].ins;
                rx_bus_next[RX_DEL_LSB + i]  = rx_lanes_i[i].del;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_channel_out_bus_o <= '0;
            rx_out_valid_o       <= 1'b0;
        end else begin
            rx_channel_out_bus_o <= rx_bus_next;
            rx_out_valid_o       <= rx_valid_next;
        end
    end

    // -----------------------------------------------------------------
    // interrupt events
    // -----------------------------------------------------------------
    always_comb begin
        irq_events               = '0;
        irq_events[IRQ_TX_UNDER] = qflag_next[QF_UNDER];
        irq_events[IRQ_TX_OVER]  = qflag_next[QF_OVER];
        for (int i = 0; i < LANES; i++) begin
            if (lane_mode && rx_word_i.valid) begin
                irq_events[IRQ_RX_DERR] = irq_events[IRQ_RX_DERR] | rx_lanes_i[i].disp_err;
                irq_events[IRQ_RX_CERR] = irq_events[IRQ_RX_CERR] | rx_lanes_i[i].code_err;
                irq_events[IRQ_RX_INS]  = irq_events[IRQ_RX_INS] | rx_lanes_i[i].ins;
                irq_events[IRQ_RX_DEL]  = irq_events[IRQ_RX_DEL] | rx_lanes_i[i].del;
            end
        end
    end

    // -----------------------------------------------------------------
    // register file
    // -----------------------------------------------------------------
    always_comb begin
        mode_next     = mode_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        rdata_next    = '0;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                REG_MODE: begin
                    // changing mode does not flush the queue; software
                    // should drain it first
                    mode_next = coding_mode_e'(reg_wdata_i[1:0]);
                end
                REG_IRQ_MASK: begin
                    irq_mask_next = reg_wdata_i[IRQ_W-1:0];
                end
                REG_IRQ_STAT: begin
                    irq_stat_next = irq_stat_reg & ~reg_wdata_i[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // applied after the clear so an event in the clearing cycle survives
        irq_stat_next = irq_stat_next | irq_events;
        irq_next      = |(irq_stat_next & irq_mask_next);
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_MODE: begin
                    rdata_next[1:0] = mode_reg;
                end
                REG_IRQ_STAT: begin
                    rdata_next[IRQ_W-1:0] = irq_stat_reg;
                end
                REG_IRQ_MASK: begin
                    rdata_next[IRQ_W-1:0] = irq_mask_reg;
                end
                REG_TXQ_STAT: begin
                    rdata_next[QF_W-1:0]                = tx_queue_flag_port_o;
                    rdata_next[TXQ_CNT_LSB +: CNT_W]    = count_reg;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_reg     <= coding_mode_e'(MODE_RESET);
            irq_stat_reg <= IRQ_RESET;
            irq_mask_reg <= IRQ_RESET;
            irq_o        <= 1'b0;
            reg_rdata_o  <= '0;
        end else begin
            mode_reg     <= mode_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_o        <= irq_next;
            reg_rdata_o  <= rdata_next;
        end
    end

endmodule

// ===== tb/pcs_fabric_port_chk.sv
// assertions on the fabric port: lane packing, queue flags and pulse causes
// assumes it is bound to pcs_fabric_port and sees only its ports
`timescale 1ns/100ps
module pcs_fabric_port_chk
    import fabric_port_pkg::*;
#(
    parameter int TXQ_DEPTH  = 16,
    parameter int TXQ_AE_LVL = 2,
    parameter int TXQ_AF_LVL = 14
) (
    input wire logic                sys_clk_i,
    input wire logic                sys_rst_i,
    input wire logic [CH_BUS_W-1:0] tx_channel_in_bus_i,
    input wire logic [QF_W-1:0]     tx_queue_flag_port_o,
    input wire logic                tx_drain_i,
    input wire rx_lanes_t           rx_lanes_i,
    input wire rx_word_s            rx_word_i,
    input wire logic [CH_BUS_W-1:0] rx_channel_out_bus_o,
    input wire logic [ADDR_W-1:0]   reg_addr_i,
    input wire logic [DATA_W-1:0]   reg_wdata_i,
    input wire logic                reg_wr_i
);
    // ----------------------------------------
    // shadow of mode and queue fill
    // ----------------------------------------
    logic [1:0]  mode_reg, mode_next, old_reg;
    int          cnt_reg, cnt_next;
    logic        held_reg, same, wr, ovf_c, unf_c;
    logic [39:0] l8, l10;
    logic [15:0] lf;
    always_comb begin
        wr = mode_reg == MODE_10GE && tx_channel_in_bus_i[TXQ_WR_BIT];
        mode_next = (reg_wr_i && reg_addr_i == REG_MODE) ? reg_wdata_i[1:0] : mode_reg;
        cnt_next = cnt_reg + int'(wr && cnt_reg < TXQ_DEPTH) - int'(tx_drain_i && cnt_reg > 0);
        ovf_c = wr && cnt_reg == TXQ_DEPTH;
        unf_c = tx_drain_i && cnt_reg == 0;
        for (int i = 0; i < LANES; i++) begin
            l8[10*i +: 10] = {rx_lanes_i[i].rundisp, rx_lanes_i[i].is_ctrl, rx_lanes_i[i].data};
            l10[10*i +: 10] = rx_lanes_i[i].sym10;
            lf[i] = rx_lanes_i[i].disp_err;
            lf[4+i] = rx_lanes_i[i].code_err;
            lf[8+i] = rx_lanes_i[i].ins;
            lf[12+i] = rx_lanes_i[i].del;
        end
    end
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_reg <= MODE_RESET;
            old_reg <= MODE_RESET;
            cnt_reg <= 0;
            held_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            old_reg <= mode_reg;
            cnt_reg <= cnt_next;
            held_reg <= 1'b1;
        end
    end
    // mode must be steady across the registering edge, else lanes may mix
    assign same = held_reg && old_reg == mode_reg;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_lane_8b10b: assert property (
        same && mode_reg == MODE_8B10B |-> rx_channel_out_bus_o[39:0] == $past(l8))
        else $error("8b10b lane packing wrong");
    a_lane_10b: assert property (
        same && mode_reg == MODE_10B |-> rx_channel_out_bus_o[39:0] == $past(l10))
        else $error("10b lane packing wrong");
    a_lane_flags: assert property (
        same && mode_reg < 2'h2 |-> rx_channel_out_bus_o[55:40] == $past(lf))
        else $error("lane flags misplaced");
    a_wide_pass: assert property (
        same && mode_reg == MODE_10GE |-> rx_channel_out_bus_o == 80'($past(rx_word_i.wide)))
        else $error("wide word altered");
    a_bypass_word: assert property (
        same && mode_reg == MODE_BYPASS |->
        rx_channel_out_bus_o == 80'($past(rx_word_i.bypass)))
        else $error("bypass word wrong");
    a_almost_flags: assert property (
        tx_queue_flag_port_o[1:0] == {cnt_reg >= TXQ_AF_LVL, cnt_reg <= TXQ_AE_LVL})
        else $error("almost flags disagree with fill");
    a_over_pulse: assert property (
        held_reg |-> tx_queue_flag_port_o[QF_OVER] == $past(ovf_c))
        else $error("overflow flag without cause");
    a_under_pulse: assert property (
        held_reg |-> tx_queue_flag_port_o[QF_UNDER] == $past(unf_c))
        else $error("underflow flag without cause");
endmodule

bind pcs_fabric_port pcs_fabric_port_chk #(
    .TXQ_DEPTH(TXQ_DEPTH),
    .TXQ_AE_LVL(TXQ_AE_LVL),
    .TXQ_AF_LVL(TXQ_AF_LVL)
) chk_i (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .tx_channel_in_bus_i(tx_channel_in_bus_i),
    .tx_queue_flag_port_o(tx_queue_flag_port_o),
    .tx_drain_i(tx_drain_i),
    .rx_lanes_i(rx_lanes_i),
    .rx_word_i(rx_word_i),
    .rx_channel_out_bus_o(rx_channel_out_bus_o),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i)
);

// ===== tb/fabric_user_model.sv
// fabric user logic that feeds the transmit queue
// assumes the queue flags arrive on the same clock
`timescale 1ns/100ps
module fabric_user_model
    import fabric_port_pkg::*;
(
    input  wire logic                sys_clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                go_i,
    input  wire logic                force_i,
    input  wire logic [QF_W-1:0]     flags_i,
    output logic      [CH_BUS_W-1:0] bus_o
);
    logic [7:0] seq_reg = 8'h00;
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seq_reg <= 8'h00;
            bus_o <= '0;
        end else begin
            // stop on almost full; force_i breaks this on purpose
            bus_o[TXQ_WR_BIT] <= go_i && (!flags_i[QF_AFULL] || force_i);
            // word changes every cycle so a stale value is never mistaken
            bus_o[71:0] <= {~seq_reg, {8{seq_reg}}};
            seq_reg <= seq_reg + 8'h01;
        end
    end
endmodule

// ===== tb/pcs_fabric_port_test.sv
// self-checking bench of the fabric port: registers, queue, receive packing
// assumes a queue shrunk to four entries
`timescale 1ns/100ps
module pcs_fabric_port_test
    import fabric_port_pkg::*;
;
    localparam int DEPTH = 4;
    logic                sys_clk_i = 0, sys_rst_i = 1, go = 0, frc = 0, tx_drain_i = 0;
    logic                reg_wr_i = 0, reg_rd_i = 0, rd_seen = 0, ovf_e = 0, unf_e = 0;
    logic                tx_v, rx_v, irq_o;
    logic [ADDR_W-1:0]   reg_addr_i = '0;
    logic [DATA_W-1:0]   reg_wdata_i = '0, reg_rdata_o, seed = 32'h84B6;
    logic [CH_BUS_W-1:0] tx_bus, rx_bus;
    logic [QF_W-1:0]     flags;
    logic [63:0]         tx_d;
    logic [7:0]          tx_c;
    rx_lanes_t           lanes = '0;
    rx_word_s            word = '0;
    logic [1:0]          mode = 2'h0;
    logic [5:0]          irq_e = '0;
    logic [79:0]         rxq[$], txq[$], rq[$];
    int                  err_total = 0, n_checks = 0;

    pcs_fabric_port #(.TXQ_DEPTH(DEPTH), .TXQ_AW(2), .TXQ_AE_LVL(1), .TXQ_AF_LVL(3)) uut (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .tx_channel_in_bus_i(tx_bus),
        .tx_queue_flag_port_o(flags), .tx_drain_i(tx_drain_i), .tx_out_valid_o(tx_v),
        .tx_out_data_o(tx_d), .tx_out_ctrl_o(tx_c), .rx_lanes_i(lanes), .rx_word_i(word),
        .rx_channel_out_bus_o(rx_bus), .rx_out_valid_o(rx_v), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
    fabric_user_model fab (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .go_i(go),
        .force_i(frc), .flags_i(flags), .bus_o(tx_bus));

    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [79:0] rx_exp(logic [1:0] m, rx_lanes_t l, rx_word_s w);
        logic [79:0] e;
        e = '0;
        if (m == MODE_10GE) e[63:0] = w.wide;
        else if (m == MODE_BYPASS) e[39:0] = w.bypass;
        else for (int i = 0; i < 4; i++) begin
            e[10*i +: 10] = m[0] ? l[i].sym10 : {l[i].rundisp, l[i].is_ctrl, l[i].data};
            e[40+i] = l[i].disp_err;
            e[44+i] = l[i].code_err;
            e[48+i] = l[i].ins;
            e[52+i] = l[i].del;
        end
        return e;
    endfunction
    task chk(string nm, logic [79:0] e, logic [79:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        // the design still packs with the old mode at this edge
        if (a == REG_MODE) mode <= d[1:0];
        if (a == REG_IRQ_STAT) irq_e &= ~d[5:0];
    endtask
    task rd(logic [7:0] a, logic [31:0] e);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        rq.push_back(80'(e));
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // expectation keeper and output watcher
    // ----------------------------------------
    always @(posedge sys_clk_i) begin
        rd_seen <= reg_rd_i;
        ovf_e <= mode == MODE_10GE && tx_bus[TXQ_WR_BIT] && txq.size() >= DEPTH;
        unf_e <= tx_drain_i && txq.size() == 0;
        if (!sys_rst_i && word.valid) rxq.push_back(rx_exp(mode, lanes, word));
        if (!sys_rst_i && word.valid && mode < 2'h2) for (int i = 0; i < 4; i++)
            irq_e[5:2] |= {lanes[i].del, lanes[i].ins, lanes[i].code_err, lanes[i].disp_err};
        // underflow is judged on the fill before this edge's push
        if (!sys_rst_i && tx_drain_i && txq.size() == 0) irq_e[0] = 1'b1;
        if (!sys_rst_i && mode == MODE_10GE && tx_bus[TXQ_WR_BIT]) begin
            if (txq.size() < DEPTH) txq.push_back(80'(tx_bus[71:0]));
            else irq_e[1] = 1'b1;
        end
    end
    always @(negedge sys_clk_i) begin
        if (!sys_rst_i) begin
            if (rx_v) chk("rx bus", rxq.pop_front(), rx_bus);
            if (tx_v) chk("tx entry", txq.pop_front(), 80'({tx_c, tx_d}));
            if (rd_seen) chk("reg read", rq.pop_front(), 80'(reg_rdata_o));
            chk("queue pulses", 80'({ovf_e, unf_e}), 80'(flags[3:2]));
        end
    end
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        err_total++;
        end_of_test();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(negedge sys_clk_i);
        chk("flags", 80'h1, 80'(flags));
        rd(REG_IRQ_MASK, 32'h0);
        rd(REG_TXQ_STAT, 32'h1);
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(REG_MODE, 32'(m));
            rd(REG_MODE, 32'(m));
            repeat (8) begin
                @(posedge sys_clk_i);
                lanes <= {rnd(), rnd(), rnd()};
                word <= {1'b1, rnd(), rnd(), rnd(), 8'(rnd())};
            end
            @(posedge sys_clk_i);
            word <= '0;
        end
        wr(REG_MODE, 32'h2);
        @(posedge sys_clk_i);
        go <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        go <= 1'b0;
        rd(REG_TXQ_STAT, 32'h402);
        @(posedge sys_clk_i);
        go <= 1'b1;
        frc <= 1'b1;
        @(posedge sys_clk_i);
        go <= 1'b0;
        frc <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        tx_drain_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        tx_drain_i <= 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk("flags", 80'h1, 80'(flags));
        rd(REG_IRQ_STAT, 32'(irq_e));
        @(negedge sys_clk_i);
        chk("irq", 80'h0, 80'(irq_o));
        wr(REG_IRQ_MASK, 32'h3F);
        rd(REG_IRQ_MASK, 32'h3F);
        @(negedge sys_clk_i);
        chk("irq", 80'h1, 80'(irq_o));
        wr(REG_IRQ_STAT, 32'h3F);
        rd(REG_IRQ_STAT, 32'h0);
        @(negedge sys_clk_i);
        chk("irq", 80'h0, 80'(irq_o));
        repeat (4) @(posedge sys_clk_i);
        end_of_test();
    end
endmodule
